// file: tb/t1c_pin_model.sv
// far-side model: drives the count pin with clean rising edges
// assumes the bench calls pulse() from its main sequence
`timescale 1ns/1ns
module t1c_pin_model (
  // clock
  input  wire logic clk_in,
  // count pin
  output logic      pin_out
);
  initial pin_out = 1'b0;

  // ---------------------------------------------------------------
  // n low-high-low cycles, pin idles low
  // ---------------------------------------------------------------
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk_in);
      pin_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      pin_out <= 1'b0;
      repeat (4) @(posedge clk_in);
    end
    repeat (8) @(posedge clk_in);
  endtask
endmodule

// file: tb/tb.sv
// self-checking bench of the timer/counter
// assumes the pin model on the count pin
`timescale 1ns/1ns
module tb;
  import t1c_pkg::*;
  logic              clk_in;
  logic              rst_n_in;
  logic              ce_in;
  logic [ADDR_W-1:0] addr_in;
  logic [7:0]        wdata_in;
  logic              wr_in;
  logic              rd_in;
  logic [7:0]        rdata_out;
  logic              pin;
  logic              irq_out;
  logic              irq_prio_out;
  logic [7:0]        v;
  logic [7:0]        w;
  int                err_count;
  int                n_compared;

  always #25 clk_in = ~clk_in;

  t1c_top u_dut (
    .clk_in          (clk_in),
    .rst_n_in        (rst_n_in),
    .ce_in           (ce_in),
    .addr_in         (addr_in),
    .wdata_in        (wdata_in),
    .wr_in           (wr_in),
    .rd_in           (rd_in),
    .rdata_out       (rdata_out),
    .ext_count_pin_in(pin),
    .irq_out         (irq_out),
    .irq_prio_out    (irq_prio_out)
  );
  t1c_pin_model u_pin (.clk_in(clk_in), .pin_out(pin));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic fail(input string m);
    $display("BAD %0t %s", $time, m);
    err_count++;
  endtask
  task automatic eq(input logic [7:0] got, input logic [7:0] exp,
                    input string m);
    n_compared++;
    if (got !== exp) fail(m);
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clk_in);
    wr_in    <= 1'b0;
  endtask
  task automatic rd_eq(input logic [ADDR_W-1:0] a, input logic [7:0] e,
                       input string m);
    @(posedge clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_in);
    rd_in   <= 1'b0;
    #1 v = rdata_out;
    eq(v, e, m);
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset_map();
    for (int i = 0; i < 8; i++) rd_eq(3'(i), 8'h00, "reset value");
    eq({7'h00, irq_out}, 8'h00, "irq at reset");
    wr(OFF_CTRL, 8'hff);
    rd_eq(OFF_CTRL, 8'hb7, "control readback");
    wr(OFF_CTRL, 8'h00);
  endtask
  task automatic t_divide();
    for (int d = 0; d < 4; d++) begin
      wr(OFF_CTRL, {2'b00, 2'(d), 4'b0100});
      wr(OFF_LOW, 8'h00);
      wr(OFF_CTRL, {2'b00, 2'(d), 4'b0101});
      repeat (62) @(posedge clk_in);
      wr(OFF_CTRL, {2'b00, 2'(d), 4'b0100});
      rd_eq(OFF_LOW, 8'(16 >> d), "divided count");
      n_compared++;
      if ((v >= 8'(16 >> d) - 8'h01 && v <= 8'(16 >> d) + 8'h01) !== 1'b1)
        fail("divided count out of range");
      w = v;
      repeat (20) @(posedge clk_in);
      rd_eq(OFF_LOW, w, "stopped count moved");
    end
  endtask
  task automatic t_ext();
    for (int b = 0; b < 2; b++) begin
      wr(OFF_CTRL, {5'b00000, 1'(b), 2'b10});
      wr(OFF_LOW, 8'h00);
      wr(OFF_CTRL, {5'b00000, 1'(b), 2'b11});
      u_pin.pulse(5);
      rd_eq(OFF_LOW, 8'h05, "pin edge count");
    end
  endtask
  task automatic t_overflow();
    wr(OFF_CTRL, 8'h02);
    wr(OFF_HIGH, 8'hff);
    wr(OFF_LOW, 8'hfe);
    wr(OFF_CTRL, 8'h03);
    u_pin.pulse(2);
    rd_eq(OFF_FLAGS, 8'h01, "flag after wrap");
    rd_eq(OFF_LOW, 8'h00, "low after wrap");
    rd_eq(OFF_HIGH, 8'h00, "high after wrap");
    eq({7'h00, irq_out}, 8'h00, "irq while masked");
    wr(OFF_ENABLE, 8'h01);
    wr(OFF_PRIORITY, 8'h01);
    repeat (2) @(posedge clk_in);
    eq({7'h00, irq_out}, 8'h01, "irq when enabled");
    eq({7'h00, irq_prio_out}, 8'h01, "priority irq");
    u_pin.pulse(1);
    rd_eq(OFF_FLAGS, 8'h01, "flag not sticky");
    wr(OFF_CLEAR, 8'h01);
    repeat (2) @(posedge clk_in);
    rd_eq(OFF_FLAGS, 8'h00, "flag not cleared");
    eq({7'h00, irq_out}, 8'h00, "irq after clear");
    wr(OFF_ENABLE, 8'h00);
    wr(OFF_PRIORITY, 8'h00);
  endtask
  task automatic t_wide();
    wr(OFF_CTRL, 8'h80);
    wr(OFF_HIGH, 8'h12);
    wr(OFF_LOW, 8'h34);
    rd_eq(OFF_LOW, 8'h34, "wide low");
    rd_eq(OFF_HIGH, 8'h12, "wide high");
    wr(OFF_HIGH, 8'h56);
    rd_eq(OFF_HIGH, 8'h56, "buffer readback");
    rd_eq(OFF_LOW, 8'h34, "wide low again");
    rd_eq(OFF_HIGH, 8'h12, "live high reached");
    wr(OFF_CTRL, 8'h00);
    wr(OFF_HIGH, 8'h77);
    rd_eq(OFF_HIGH, 8'h77, "direct high");
    rd_eq(OFF_LOW, 8'h34, "low disturbed");
  endtask
  task automatic t_prescale_clear();
    wr(OFF_CTRL, 8'h32);
    wr(OFF_LOW, 8'h00);
    wr(OFF_CTRL, 8'h33);
    u_pin.pulse(4);
    wr(OFF_HIGH, 8'h00);
    u_pin.pulse(4);
    rd_eq(OFF_LOW, 8'h01, "high write cleared prescaler");
    u_pin.pulse(4);
    wr(OFF_LOW, 8'h00);
    u_pin.pulse(4);
    rd_eq(OFF_LOW, 8'h00, "low write kept prescaler");
    wr(OFF_CTRL, 8'h00);
  endtask
  task automatic t_freeze();
    wr(OFF_CTRL, 8'h00);
    wr(OFF_LOW, 8'h00);
    @(posedge clk_in);
    ce_in <= 1'b0;
    wr(OFF_CTRL, 8'h01);
    wr(OFF_LOW, 8'h55);
    repeat (40) @(posedge clk_in);
    ce_in <= 1'b1;
    rd_eq(OFF_CTRL, 8'h00, "control written while frozen");
    rd_eq(OFF_LOW, 8'h00, "count written while frozen");
  endtask

  // ---------------------------------------------------------------
  // main sequence and time limit
  // ---------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    rst_n_in = 1'b0;
    ce_in = 1'b1;
    addr_in = '0;
    wdata_in = 8'h00;
    wr_in = 1'b0;
    rd_in = 1'b0;
    err_count = 0;
    n_compared = 0;
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_reset_map();
    t_divide();
    t_ext();
    t_overflow();
    t_wide();
    t_prescale_clear();
    t_freeze();
    tally_and_finish();
  end
  initial begin
    repeat (60000) @(posedge clk_in);
    fail("time limit");
    tally_and_finish();
  end
endmodule

// file: verilog/t1c_pkg.sv
// constants, types and register map of the 16-bit timer/counter
// assumes a single 20 MHz clock and a byte-wide register port
// ---------------------------------------------------------------
// ---------------------------------------------------------------
package t1c_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam int          ADDR_W       = 3;
  localparam logic [2:0]  OFF_CTRL     = 3'h0;
  localparam logic [2:0]  OFF_LOW      = 3'h1;
  localparam logic [2:0]  OFF_HIGH     = 3'h2;
  localparam logic [2:0]  OFF_FLAGS    = 3'h3;
  localparam logic [2:0]  OFF_ENABLE   = 3'h4;
  localparam logic [2:0]  OFF_PRIORITY = 3'h5;
  localparam logic [2:0]  OFF_CLEAR    = 3'h6;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int          BIT_RUN      = 0;
  localparam int          BIT_SRC      = 1;
  localparam int          BIT_BYPASS   = 2;
  localparam int          BIT_DIV_LO   = 4;
  localparam int          BIT_DIV_HI   = 5;
  localparam int          BIT_WIDE     = 7;
  localparam int          BIT_OVF      = 0;
  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  localparam logic [15:0] COUNT_RESET  = 16'h0000;
  localparam logic [15:0] COUNT_MAX    = 16'hffff;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int          CLK_HZ       = 20_000_000;
  localparam int          INSTR_DIV    = 4;
  localparam logic [1:0]  INSTR_LAST   = 2'(INSTR_DIV - 1);

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       wide;
    logic [1:0] div_sel;
    logic       bypass;
    logic       src;
    logic       run;
  } t1c_ctrl_s;

  typedef struct packed {
    t1c_ctrl_s   ctrl;
    logic [15:0] count;
    logic [7:0]  hbuf;
    logic [2:0]  pre;
    logic [1:0]  phase;
    logic        s1;
    logic        s2;
    logic        prev;
    logic        pend;
    logic        flag;
    logic        ie;
    logic        ip;
    logic [7:0]  rdata;
    logic        irq;
    logic        irq_prio;
  } t1c_state_s;

endpackage

// file: verilog/t1c_top.sv
// 16-bit timer/counter with prescaler, pin source and buffered access
// assumes register port on clk_in; count pin is asynchronous
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ns
module t1c_top
  import t1c_pkg::*;
(
  // clock, reset, enable
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              ce_in,
  // register port
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [7:0]        wdata_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  output logic      [7:0]        rdata_out,
  // count pin
  input  wire logic              ext_count_pin_in,
  // interrupt
  output logic                   irq_out,
  output logic                   irq_prio_out
);

  t1c_state_s r;
  t1c_state_s next_r;

  logic       itick;
  logic       ext_rise;
  logic       src_tick;
  logic [2:0] pre_mask;
  logic       pre_wrap;
  logic       wr_low;
  logic       wr_high;
  logic       rd_low;
  logic       rd_high;
  logic       inc;

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    next_r   = r;
    wr_low   = wr_in && (addr_in == OFF_LOW);
    wr_high  = wr_in && (addr_in == OFF_HIGH);
    rd_low   = rd_in && (addr_in == OFF_LOW);
    rd_high  = rd_in && (addr_in == OFF_HIGH);
    itick    = (r.phase == INSTR_LAST);
    ext_rise = r.s2 && !r.prev;
    // source select
    if (!r.ctrl.src) begin
      src_tick = itick;
    end else if (r.ctrl.bypass) begin
      src_tick = ext_rise;
    end else begin
      src_tick = (r.pend || ext_rise) && itick;
    end
    unique case (r.ctrl.div_sel)
      2'b00: pre_mask = 3'h0;
      2'b01: pre_mask = 3'h1;
      2'b10: pre_mask = 3'h3;
      2'b11: pre_mask = 3'h7;
    endcase
    pre_wrap = (r.pre == pre_mask);
    inc      = r.ctrl.run && src_tick && pre_wrap
               && !wr_low && !wr_high;

    // pin synchroniser and edge detect
    next_r.s1    = ext_count_pin_in;
    next_r.s2    = r.s1;
    next_r.prev  = r.s2;
    next_r.pend  = r.ctrl.src && !r.ctrl.bypass
                   && (r.pend || ext_rise) && !itick;
    next_r.phase = 2'(r.phase + 2'h1);

    // prescaler
    if (wr_low) begin
      next_r.pre = 3'h0;
    end else if (r.ctrl.run && src_tick && !wr_high) begin
      next_r.pre = pre_wrap ? 3'h0 : 3'(r.pre + 3'h1);
    end

    // counter and wrap
    if (inc) begin
      next_r.count = 16'(r.count + 16'h0001);
      if (r.count == COUNT_MAX) begin
        next_r.flag = 1'b1;
      end
    end

    // register writes
    if (wr_in) begin
      unique case (addr_in)
        OFF_CTRL: begin
          next_r.ctrl.wide    = wdata_in[BIT_WIDE];
          next_r.ctrl.div_sel = wdata_in[BIT_DIV_HI:BIT_DIV_LO];
          next_r.ctrl.bypass  = wdata_in[BIT_BYPASS];
          next_r.ctrl.src     = wdata_in[BIT_SRC];
          next_r.ctrl.run     = wdata_in[BIT_RUN];
        end
        OFF_LOW: begin
          next_r.count[7:0] = wdata_in;
          if (r.ctrl.wide) begin
            next_r.count[15:8] = r.hbuf;
          end
        end
        OFF_HIGH: begin
          if (r.ctrl.wide) begin
            next_r.hbuf = wdata_in;
          end else begin
            next_r.count[15:8] = wdata_in;
          end
        end
        OFF_ENABLE:   next_r.ie = wdata_in[BIT_OVF];
        OFF_PRIORITY: next_r.ip = wdata_in[BIT_OVF];
        OFF_CLEAR: begin
          if (wdata_in[BIT_OVF] && !(inc && r.count == COUNT_MAX)) begin
            next_r.flag = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // register reads, data in the following cycle
    next_r.rdata = 8'h00;
    if (rd_in) begin
      unique case (addr_in)
        OFF_CTRL: next_r.rdata = {r.ctrl.wide, 1'b0, r.ctrl.div_sel,
                                  1'b0, r.ctrl.bypass, r.ctrl.src,
                                  r.ctrl.run};
        OFF_LOW:  next_r.rdata = r.count[7:0];
        OFF_HIGH: next_r.rdata = r.ctrl.wide ? r.hbuf
                                             : r.count[15:8];
        OFF_FLAGS:    next_r.rdata = {7'h00, r.flag};
        OFF_ENABLE:   next_r.rdata = {7'h00, r.ie};
        OFF_PRIORITY: next_r.rdata = {7'h00, r.ip};
        default:      next_r.rdata = 8'h00;
      endcase
      if (rd_low && r.ctrl.wide) begin
        next_r.hbuf = r.count[15:8];
      end
    end

    // interrupt
    next_r.irq      = next_r.flag && next_r.ie;
    next_r.irq_prio = next_r.flag && next_r.ie && next_r.ip;
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r       <= '0;
      r.ctrl  <= t1c_ctrl_s'({CTRL_RESET[BIT_WIDE],
                              CTRL_RESET[BIT_DIV_HI:BIT_DIV_LO],
                              CTRL_RESET[BIT_BYPASS:BIT_RUN]});
      r.count <= COUNT_RESET;
      r.prev  <= 1'b1;
    end else if (ce_in) begin
      r <= next_r;
    end
  end

  assign rdata_out    = r.rdata;
  assign irq_out      = r.irq;
  assign irq_prio_out = r.irq_prio;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_rise;
    ce_in && r.s2 && !r.prev && r.ctrl.src;
  endsequence

  sequence s_quiet;
    ce_in && !wr_low && !wr_high;
  endsequence

  sequence s_ctrl_write;
    ce_in && wr_in && addr_in == OFF_CTRL;
  endsequence

  sequence s_read(logic [ADDR_W-1:0] a);
    ce_in && rd_in && addr_in == a;
  endsequence

  sequence s_clear_write;
    ce_in && wr_in && addr_in == OFF_CLEAR && wdata_in[BIT_OVF];
  endsequence

  a_stop_holds: assert property (
    s_quiet and (!r.ctrl.run) |=> r.count == $past(r.count))
    else $error("stopped counter moved");

  a_ctrl_zero_bits: assert property (
    ce_in && rd_in && addr_in == OFF_CTRL |=> !rdata_out[6] && !rdata_out[3])
    else $error("unimplemented control bit read as one");

  a_prescale_wrap: assert property (
    s_quiet and (r.ctrl.run && src_tick && pre_wrap) |=> r.pre == 3'h0)
    else $error("prescaler failed to wrap");

  a_int_no_tick: assert property (
    s_quiet and (!r.ctrl.src && !itick) |=> r.count == $past(r.count))
    else $error("internal source counted off instruction tick");

  a_bypass_edge: assert property (
    s_rise and (r.ctrl.bypass && r.ctrl.run && !wr_low && !wr_high)
    |=> r.pre != $past(r.pre) || r.count != $past(r.count))
    else $error("bypassed edge not counted");

  a_sync_pending: assert property (
    s_rise and (!r.ctrl.bypass && !itick) |=> r.pend)
    else $error("synchronised edge lost");

  a_wrap_zero: assert property (
    ce_in && inc && r.count == COUNT_MAX |=> r.count == COUNT_RESET)
    else $error("count did not wrap to zero");

  a_wrap_flag: assert property (
    ce_in && inc && r.count == COUNT_MAX |=> r.flag [*1] ##1 1)
    else $error("overflow flag not set");

  a_irq_gate: assert property (
    irq_out == (r.flag && r.ie))
    else $error("interrupt output disagrees with flag and enable");

  a_high_buffer: assert property (
    ce_in && rd_high && r.ctrl.wide |=> rdata_out == $past(r.hbuf))
    else $error("buffered high read not from buffer");

  a_low_read_copy: assert property (
    ce_in && rd_low && r.ctrl.wide |=> r.hbuf == $past(r.count[15:8]))
    else $error("low read did not latch high byte");

  a_low_write_load: assert property (
    ce_in && wr_low && r.ctrl.wide
    |=> r.count == {$past(r.hbuf), $past(wdata_in)})
    else $error("low write did not load all sixteen bits");

  a_low_write_pre: assert property (
    ce_in && wr_low |=> r.pre == 3'h0)
    else $error("low write left prescaler");

  a_direct_high: assert property (
    ce_in && wr_high && !r.ctrl.wide |=> r.count[15:8] == $past(wdata_in))
    else $error("unbuffered high write missed");

  a_ctrl_run_bit: assert property (
    s_ctrl_write |=> r.ctrl.run == $past(wdata_in[BIT_RUN]))
    else $error("run bit not written");

  a_ctrl_wide_bit: assert property (
    s_ctrl_write |=> r.ctrl.wide == $past(wdata_in[BIT_WIDE]))
    else $error("wide access bit not written");

  a_ctrl_div_bits: assert property (
    s_ctrl_write |=> r.ctrl.div_sel == $past(wdata_in[5:4]))
    else $error("divider select not written");

  a_ctrl_bypass_bit: assert property (
    s_ctrl_write |=> r.ctrl.bypass == $past(wdata_in[BIT_BYPASS]))
    else $error("bypass bit not written");

  a_ctrl_src_bit: assert property (
    s_ctrl_write |=> r.ctrl.src == $past(wdata_in[BIT_SRC]))
    else $error("source bit not written");

  a_ctrl_read_back: assert property (
    s_read(OFF_CTRL) |=> rdata_out[7] == $past(r.ctrl.wide))
    else $error("wide bit read back wrong");

  a_run_advance: assert property (
    s_quiet and (r.ctrl.run && src_tick && pre_wrap)
    |=> r.count == 16'($past(r.count) + 16'h0001))
    else $error("running counter did not advance");

  a_no_tick_hold: assert property (
    s_quiet and (!src_tick) |=> r.count == $past(r.count))
    else $error("count moved without source tick");

  a_pre_stopped: assert property (
    ce_in && !wr_low && !r.ctrl.run |=> r.pre == $past(r.pre))
    else $error("prescaler moved while stopped");

  a_pre_step: assert property (
    s_quiet and (r.ctrl.run && src_tick && !pre_wrap)
    |=> r.pre == 3'($past(r.pre) + 3'h1))
    else $error("prescaler did not step");

  a_int_ignore_bypass: assert property (
    ce_in && !r.ctrl.src |-> src_tick == itick)
    else $error("internal source used the bypass bit");

  a_int_tick_count: assert property (
    s_quiet and (!r.ctrl.src && r.ctrl.run && itick && pre_wrap)
    |=> r.count == 16'($past(r.count) + 16'h0001))
    else $error("instruction tick not counted");

  a_phase_step: assert property (
    ce_in |=> r.phase == 2'($past(r.phase) + 2'h1))
    else $error("instruction phase did not step");

  a_sync_wait: assert property (
    ce_in && r.ctrl.src && !r.ctrl.bypass && !itick |-> !src_tick)
    else $error("synchronised edge counted off tick");

  a_sync_release: assert property (
    ce_in && r.ctrl.src && !r.ctrl.bypass && itick
    && (r.pend || ext_rise) |-> src_tick)
    else $error("pending edge not released on tick");

  a_bypass_direct: assert property (
    ce_in && r.ctrl.src && r.ctrl.bypass |-> src_tick == ext_rise)
    else $error("bypassed edge not taken directly");

  a_sync_stage: assert property (
    ce_in |=> r.s2 == $past(r.s1))
    else $error("second synchroniser stage wrong");

  a_edge_history: assert property (
    ce_in |=> r.prev == $past(r.s2))
    else $error("edge history wrong");

  a_flag_sticky: assert property (
    ce_in && r.flag
    && !(wr_in && addr_in == OFF_CLEAR && wdata_in[BIT_OVF]) |=> r.flag)
    else $error("overflow flag dropped without clear");

  a_flag_no_set: assert property (
    ce_in && !r.flag && !(inc && r.count == COUNT_MAX) |=> !r.flag)
    else $error("overflow flag set without wrap");

  a_flag_clear: assert property (
    s_clear_write and (!(inc && r.count == COUNT_MAX)) |=> !r.flag)
    else $error("overflow flag not cleared");

  a_clear_vs_wrap: assert property (
    s_clear_write and (inc && r.count == COUNT_MAX) |=> r.flag)
    else $error("clear beat a wrap in the same cycle");

  a_flag_read: assert property (
    s_read(OFF_FLAGS) |=> rdata_out == {7'h00, $past(r.flag)})
    else $error("flag register read wrong");

  a_irq_masked: assert property (
    !r.ie |-> !irq_out)
    else $error("interrupt raised while disabled");

  a_prio_gate: assert property (
    irq_prio_out == (r.flag && r.ie && r.ip))
    else $error("priority interrupt disagrees");

  a_enable_write: assert property (
    ce_in && wr_in && addr_in == OFF_ENABLE
    |=> r.ie == $past(wdata_in[BIT_OVF]))
    else $error("enable bit not written");

  a_enable_read: assert property (
    s_read(OFF_ENABLE) |=> rdata_out == {7'h00, $past(r.ie)})
    else $error("enable register read wrong");

  a_high_write_buf: assert property (
    ce_in && wr_high && r.ctrl.wide |=> r.hbuf == $past(wdata_in)
    && r.count[15:8] == $past(r.count[15:8]))
    else $error("buffered high write reached live byte");

  a_low_read_data: assert property (
    s_read(OFF_LOW) |=> rdata_out == $past(r.count[7:0]))
    else $error("low byte read wrong");

  a_high_write_pre: assert property (
    ce_in && wr_high |=> r.pre == $past(r.pre))
    else $error("high write moved prescaler");

  a_direct_high_read: assert property (
    s_read(OFF_HIGH) and (!r.ctrl.wide)
    |=> rdata_out == $past(r.count[15:8]))
    else $error("unbuffered high read wrong");

  a_low_write_keep: assert property (
    ce_in && wr_low && !r.ctrl.wide
    |=> r.count[15:8] == $past(r.count[15:8]))
    else $error("unbuffered low write moved high byte");

endmodule
